// *** hdl/system_clock_control.v ***
// System clock control: gating, oscillator enables, master mux, dividers, monitors, clock out
// How it works
// - Each peripheral clock runs only while its gate bit is one.
// - Four 4-bit oscillator enable fields; nonzero enables, zero disables.
// - Sub crystal enable field cleared only by power-on or low-voltage reset.
// - Master clock source chosen by 3-bit code; reserved codes are ignored.
// - AHB clock is master clock divided by 2^code, codes 0 to 9.
// - APB clock is AHB clock divided by 2^code, codes 0 to 4.
// - PLL source bit picks fast internal (0) or main crystal (1).
// - PLL source pre-divided by 1, 2, 4 or 8.
// - Three monitor groups: enable, interrupt enable, fail flag, stopped status.
// - Stopped status is one while the monitored clock does not toggle.
// - Fail flag sets on clock error, cleared by writing one to it.
// - Clock error interrupt requested only while its enable bit is one.
// - A source is monitored only while its oscillator is enabled, except a master clock taken from the PLL.
// - Monitoring windows are timed by the slow internal oscillator.
// - Clock-out source chosen by 3-bit code at bits 7:5.
// - Clock-out pin drives the clock only when bit 4 is one, else low.
// - Clock-out divider zero passes through, else divides by twice its value.
// - Selected priority level becomes NMI source while enable bit 15 is one.
// - Second motor PWM protection interrupt routed to NMI when bit 6 set.
// - Master clock error interrupt routed to NMI when bit 1 set.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"

module system_clock_control (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        powerRst_n,
    input  wire [31:0] addr,
    input  wire [31:0] wrData,
    input  wire        wrStrobe,
    input  wire        rdStrobe,
    output reg  [31:0] rdData,
    input  wire        slowInternalOsc,
    input  wire        subCrystalOsc,
    input  wire        fastInternalOsc,
    input  wire        mainCrystalOsc,
    input  wire        pllOutputClock,
    input  wire        pwmBProtectIrq,
    output wire        subCrystalEnable,
    output wire        slowInternalOscEnable,
    output wire        fastInternalOscEnable,
    output wire        mainCrystalEnable,
    output wire        subCrystalPowerDownKeep,
    output reg         masterClock,
    output reg         ahbClock,
    output reg         apbClock,
    output reg  [31:0] peripheralClock,
    output reg         pllInputClock,
    output reg         clockOutPin,
    output wire        subCrystalFailIrq,
    output wire        masterFailIrq,
    output wire        mainCrystalFailIrq,
    output wire [7:0]  nmiPrioritySource,
    output wire        nmiPriorityEnable,
    output wire        nmiRequest
);

    reg  [31:0] gate_reg;
    reg  [3:0]  subEnField_reg;
    reg  [11:0] oscEnLow_reg;
    reg  [31:0] clockSelect_reg;
    reg  [11:0] monitorCtl_reg;
    reg  [2:0]  failFlag_reg;
    reg  [2:0]  stopped_reg;
    reg  [7:0]  clockOut_reg;
    reg  [31:0] nmiCtl_reg;
    reg  [2:0]  masterSel_reg;
    reg  [3:0]  ahbDiv_reg;
    reg  [2:0]  apbDiv_reg;
    reg         masterPrev_reg;
    reg  [8:0]  masterCnt_reg;
    reg         ahbPrev_reg;
    reg  [3:0]  ahbCnt_reg;
    reg  [31:0] gateEff_reg;
    reg         pllSrcPrev_reg;
    reg  [2:0]  pllCnt_reg;
    reg         outSrcPrev_reg;
    reg  [3:0]  outCnt_reg;
    reg         outDiv_reg;
    reg         slowPrev_reg;
    reg  [2:0]  monPrev_reg;
    reg  [2:0]  monSeen_reg;
    wire [2:0]  masterReq;
    wire [3:0]  ahbReq;
    wire [2:0]  apbReq;
    wire        pllSrcLevel;
    wire [2:0]  outSrcCode;
    wire [3:0]  outDivCode;
    wire        outSrcLevel;
    wire        slowRise;
    wire [2:0]  monLevel;
    wire [2:0]  monOscOn;
    wire [2:0]  monActive;
    wire [2:0]  monIrqEn;
    wire [2:0]  failClear;
    wire        masterOscOn;
    wire [11:0] monitorRead;
    wire [15:0] oscRead;
    wire [31:0] monitorWrite;

    // Clock level of a master-mux code; reserved codes give zero
    function masterLevel;
        input [2:0] code;
        input       slowL;
        input       subL;
        input       fastL;
        input       mainL;
        input       pllL;
        begin
            case (code)
                `SRC_SLOW: masterLevel = slowL;
                `SRC_SUB:  masterLevel = subL;
                `SRC_FAST: masterLevel = fastL;
                `SRC_MAIN: masterLevel = mainL;
                `SRC_PLL:  masterLevel = pllL;
                default:   masterLevel = 1'b0;
            endcase
        end
    endfunction
    function masterCodeValid;
        input [2:0] code;
        begin
            case (code)
                `SRC_SLOW, `SRC_SUB, `SRC_FAST, `SRC_MAIN, `SRC_PLL: masterCodeValid = 1'b1;
                default: masterCodeValid = 1'b0;
            endcase
        end
    endfunction
    // Tap of a ripple count giving division by 2^code; code zero is handled by the caller
    function tapBit;
        input [8:0] cnt;
        input [3:0] code;
        reg   [8:0] shifted;
        begin
            shifted = 9'h000;
            if (code != 4'h0) begin
                shifted = cnt >> (code - 4'h1);
            end
            tapBit = shifted[0];
        end
    endfunction
    function risingEdge;
        input nowL;
        input prevL;
        begin
            risingEdge = nowL & ~prevL;
        end
    endfunction

    assign subCrystalEnable        = (subEnField_reg != 4'h0);
    assign subCrystalPowerDownKeep = (subEnField_reg == `SUB_POWER_DOWN_KEEP);
    assign slowInternalOscEnable   = (oscEnLow_reg[`SLOW_EN_HI:`SLOW_EN_LO] != 4'h0);
    assign fastInternalOscEnable   = (oscEnLow_reg[`FAST_EN_HI:`FAST_EN_LO] != 4'h0);
    assign mainCrystalEnable       = (oscEnLow_reg[`MAIN_EN_HI:`MAIN_EN_LO] != 4'h0);
    assign masterReq  = clockSelect_reg[`MASTER_SEL_HI:`MASTER_SEL_LO];
    assign ahbReq     = clockSelect_reg[`AHB_DIV_HI:`AHB_DIV_LO];
    assign apbReq     = clockSelect_reg[`APB_DIV_HI:`APB_DIV_LO];
    assign outSrcCode = clockOut_reg[`CLOCK_OUT_PIN_SRC_HI:`CLOCK_OUT_PIN_SRC_LO];
    assign outDivCode = clockOut_reg[`CLOCK_OUT_PIN_DIV_HI:`CLOCK_OUT_PIN_DIV_LO];
    // PLL source: fast internal or main crystal
    assign pllSrcLevel = clockSelect_reg[`PLL_SRC_BIT] ? mainCrystalOsc : fastInternalOsc;
    assign outSrcLevel = (outSrcCode == `SRC_MASTER)   ? masterClock     :
                         (outSrcCode == `SRC_FAST_OUT) ? fastInternalOsc :
                         (outSrcCode == `SRC_FAST)     ? 1'b0            :
                         masterLevel(outSrcCode, slowInternalOsc, subCrystalOsc, 1'b0,
                                     mainCrystalOsc, pllOutputClock);
    // Monitor groups: [2] sub crystal, [1] master clock, [0] main crystal
    assign masterOscOn = masterLevel(masterSel_reg, slowInternalOscEnable, subCrystalEnable,
                                     fastInternalOscEnable, mainCrystalEnable, 1'b1);
    assign monLevel  = {subCrystalOsc, masterClock, mainCrystalOsc};
    assign monOscOn  = {subCrystalEnable, masterOscOn, mainCrystalEnable};
    assign slowRise  = risingEdge(slowInternalOsc, slowPrev_reg);
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : monGroup
            assign monActive[g] = monitorCtl_reg[g * `MON_GROUP_WIDTH + `MON_ENABLE_POS]
                                  & monOscOn[g];
            assign monIrqEn[g]  = monitorCtl_reg[g * `MON_GROUP_WIDTH + `MON_IRQ_EN_POS];
            assign failClear[g] = wrStrobe && (addr == `ADDR_CLOCK_MONITOR)
                                  && wrData[g * `MON_GROUP_WIDTH + `MON_FAIL_POS];
            assign monitorRead[g * `MON_GROUP_WIDTH + `MON_GROUP_WIDTH - 1:
                               g * `MON_GROUP_WIDTH] =
                {monitorCtl_reg[g * `MON_GROUP_WIDTH + `MON_ENABLE_POS],
                 monIrqEn[g], failFlag_reg[g], stopped_reg[g]};
        end
    endgenerate
    assign subCrystalFailIrq  = failFlag_reg[`MON_SUB] & monIrqEn[`MON_SUB];
    assign masterFailIrq      = failFlag_reg[`MON_MASTER] & monIrqEn[`MON_MASTER];
    assign mainCrystalFailIrq = failFlag_reg[`MON_MAIN] & monIrqEn[`MON_MAIN];
    assign nmiPrioritySource = nmiCtl_reg[`NMI_PRIO_HI:`NMI_PRIO_LO];
    assign nmiPriorityEnable = nmiCtl_reg[`NMI_GLOBAL_BIT];
    assign nmiRequest = (pwmBProtectIrq & nmiCtl_reg[`NMI_PWM_B_PROT_BIT])
                      | (masterFailIrq & nmiCtl_reg[`NMI_MASTER_FAIL_BIT]);

    assign oscRead = {subEnField_reg, oscEnLow_reg};
    assign monitorWrite = wrData & `MASK_MONITOR_CONTROL;
    // Sub crystal enable survives every reset except power-on and low-voltage
    always @(posedge clk or negedge powerRst_n) begin
        if (!powerRst_n) begin
            subEnField_reg <= 4'h0;
        end else if (wrStrobe && addr == `ADDR_OSC_SOURCE_ENABLE) begin
            subEnField_reg <= wrData[`SUB_EN_HI:`SUB_EN_LO];
        end
    end

    // Register writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg        <= `RST_PERIPH_GATE_TWO;
            oscEnLow_reg    <= {`RST_SLOW_OSC_FIELD, 8'h00};
            clockSelect_reg <= 32'h00000000;
            monitorCtl_reg  <= 12'h000;
            clockOut_reg    <= 8'h00;
            nmiCtl_reg      <= 32'h00000000;
        end else if (wrStrobe) begin
            case (addr)
                `ADDR_PERIPH_GATE_TWO:   gate_reg <= wrData & `MASK_PERIPH_GATE_TWO;
                `ADDR_OSC_SOURCE_ENABLE: oscEnLow_reg <= wrData[`SLOW_EN_HI:`MAIN_EN_LO];
                `ADDR_SYS_CLOCK_SELECT:  clockSelect_reg <= wrData & `MASK_SYS_CLOCK_SELECT;
                `ADDR_CLOCK_MONITOR:     monitorCtl_reg <= monitorWrite[11:0];
                `ADDR_CLOCK_OUTPUT:      clockOut_reg <= wrData[7:0];
                `ADDR_NMI_CONTROL:       nmiCtl_reg <= wrData & `MASK_NMI_CONTROL;
                default: ;
            endcase
        end
    end

    // Register reads, data valid the cycle after the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= 32'h00000000;
        end else if (rdStrobe) begin
            case (addr)
                `ADDR_PERIPH_GATE_TWO:   rdData <= gate_reg;
                `ADDR_OSC_SOURCE_ENABLE: rdData <= {16'h0000, oscRead};
                `ADDR_SYS_CLOCK_SELECT:  rdData <= clockSelect_reg;
                `ADDR_CLOCK_MONITOR:     rdData <= {20'h00000, monitorRead};
                `ADDR_CLOCK_OUTPUT:      rdData <= {24'h000000, clockOut_reg};
                `ADDR_NMI_CONTROL:       rdData <= nmiCtl_reg;
                default:                 rdData <= 32'h00000000;
            endcase
        end else begin
            rdData <= 32'h00000000;
        end
    end

    // Master mux and bus clock dividers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            masterSel_reg  <= `SRC_SLOW;
            masterClock    <= 1'b0;
            masterPrev_reg <= 1'b0;
            masterCnt_reg  <= 9'h000;
            ahbDiv_reg     <= 4'h0;
            apbDiv_reg     <= 3'h0;
            ahbClock       <= 1'b0;
            ahbPrev_reg    <= 1'b0;
            ahbCnt_reg     <= 4'h0;
            apbClock       <= 1'b0;
        end else begin
            // Switch only while both the old and the new source sit low
            if (masterCodeValid(masterReq) && masterReq != masterSel_reg
                && !masterLevel(masterSel_reg, slowInternalOsc, subCrystalOsc,
                                fastInternalOsc, mainCrystalOsc, pllOutputClock)
                && !masterLevel(masterReq, slowInternalOsc, subCrystalOsc,
                                fastInternalOsc, mainCrystalOsc, pllOutputClock)) begin
                masterSel_reg <= masterReq;
            end
            masterClock <= masterLevel(masterSel_reg, slowInternalOsc, subCrystalOsc,
                                       fastInternalOsc, mainCrystalOsc, pllOutputClock);
            masterPrev_reg <= masterClock;
            if (risingEdge(masterClock, masterPrev_reg)) begin
                masterCnt_reg <= masterCnt_reg + 9'h001;
                // Divider codes take effect at a master edge; reserved codes are ignored
                if (ahbReq <= `AHB_DIV_MAX) begin
                    ahbDiv_reg <= ahbReq;
                end
                if (apbReq <= `APB_DIV_MAX) begin
                    apbDiv_reg <= apbReq;
                end
            end
            ahbClock <= (ahbDiv_reg == 4'h0) ? masterClock
                                             : tapBit(masterCnt_reg, ahbDiv_reg);
            ahbPrev_reg <= ahbClock;
            if (risingEdge(ahbClock, ahbPrev_reg)) begin
                ahbCnt_reg <= ahbCnt_reg + 4'h1;
            end
            apbClock <= (apbDiv_reg == 3'h0) ? ahbClock
                                             : tapBit({5'h00, ahbCnt_reg}, {1'b0, apbDiv_reg});
        end
    end

    // Peripheral gates change only while the bus clock is low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gateEff_reg     <= `RST_PERIPH_GATE_TWO;
            peripheralClock <= 32'h00000000;
        end else begin
            if (!apbClock) begin
                gateEff_reg <= gate_reg;
            end
            peripheralClock <= {32{apbClock}} & gateEff_reg;
        end
    end

    // PLL input prescaler
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pllSrcPrev_reg <= 1'b0;
            pllCnt_reg     <= 3'h0;
            pllInputClock  <= 1'b0;
        end else begin
            pllSrcPrev_reg <= pllSrcLevel;
            if (risingEdge(pllSrcLevel, pllSrcPrev_reg)) begin
                pllCnt_reg <= pllCnt_reg + 3'h1;
            end
            pllInputClock <= (clockSelect_reg[`PLL_PRE_HI:`PLL_PRE_LO] == 2'h0) ? pllSrcLevel
                : tapBit({6'h00, pllCnt_reg},
                         {2'h0, clockSelect_reg[`PLL_PRE_HI:`PLL_PRE_LO]});
        end
    end

    // Clock output divider and pin
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outSrcPrev_reg <= 1'b0;
            outCnt_reg     <= 4'h0;
            outDiv_reg     <= 1'b0;
            clockOutPin    <= 1'b0;
        end else begin
            outSrcPrev_reg <= outSrcLevel;
            if (risingEdge(outSrcLevel, outSrcPrev_reg) && outDivCode != 4'h0) begin
                // Toggle every divider-value source edges: period is twice the value
                if (outCnt_reg >= outDivCode - 4'h1) begin
                    outCnt_reg <= 4'h0;
                    outDiv_reg <= ~outDiv_reg;
                end else begin
                    outCnt_reg <= outCnt_reg + 4'h1;
                end
            end
            if (!clockOut_reg[`CLOCK_OUT_PIN_EN_BIT]) begin
                clockOutPin <= 1'b0;
            end else if (outDivCode == 4'h0) begin
                clockOutPin <= outSrcLevel;
            end else begin
                clockOutPin <= outDiv_reg;
            end
        end
    end

    // Clock monitors: a source that shows no rising edge in one slow-oscillator period failed
    integer k;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slowPrev_reg <= 1'b0;
            monPrev_reg  <= 3'h0;
            monSeen_reg  <= 3'h0;
            stopped_reg  <= 3'h0;
            failFlag_reg <= 3'h0;
        end else begin
            slowPrev_reg <= slowInternalOsc;
            monPrev_reg  <= monLevel;
            for (k = 0; k < 3; k = k + 1) begin
                if (!monActive[k]) begin
                    monSeen_reg[k] <= 1'b0;
                    stopped_reg[k] <= 1'b0;
                    if (failClear[k]) begin
                        failFlag_reg[k] <= 1'b0;
                    end
                end else if (slowRise) begin
                    monSeen_reg[k] <= 1'b0;
                    stopped_reg[k] <= ~monSeen_reg[k];
                    if (!monSeen_reg[k]) begin
                        failFlag_reg[k] <= 1'b1;
                    end else if (failClear[k]) begin
                        failFlag_reg[k] <= 1'b0;
                    end
                end else begin
                    if (risingEdge(monLevel[k], monPrev_reg[k])) begin
                        monSeen_reg[k] <= 1'b1;
                    end
                    if (failClear[k]) begin
                        failFlag_reg[k] <= 1'b0;
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/clock_control_defines.vh ***
// Register map, field positions, reset values and codes of the system clock control block
`ifndef CLOCK_CONTROL_DEFINES_VH
`define CLOCK_CONTROL_DEFINES_VH

`define ADDR_PERIPH_GATE_TWO     32'h40000034
`define ADDR_OSC_SOURCE_ENABLE   32'h40000040
`define ADDR_SYS_CLOCK_SELECT    32'h40000044
`define ADDR_CLOCK_MONITOR       32'h40000048
`define ADDR_CLOCK_OUTPUT        32'h40000050
`define ADDR_NMI_CONTROL         32'h40000054

`define RST_PERIPH_GATE_TWO      32'h00000101
`define MASK_PERIPH_GATE_TWO     32'hF1733F37
`define RST_SLOW_OSC_FIELD       4'h1
`define MASK_SYS_CLOCK_SELECT    32'h0F071307
`define MASK_MONITOR_CONTROL     32'h00000CCC
`define MASK_CLOCK_OUTPUT        32'h000000FF
`define MASK_NMI_CONTROL         32'h00FF807F

`define SUB_EN_HI                15
`define SUB_EN_LO                12
`define SLOW_EN_HI               11
`define SLOW_EN_LO               8
`define FAST_EN_HI               7
`define FAST_EN_LO               4
`define MAIN_EN_HI               3
`define MAIN_EN_LO               0
`define SUB_POWER_DOWN_KEEP      4'hC

`define AHB_DIV_HI               27
`define AHB_DIV_LO               24
`define APB_DIV_HI               18
`define APB_DIV_LO               16
`define PLL_SRC_BIT              12
`define PLL_PRE_HI               9
`define PLL_PRE_LO               8
`define MASTER_SEL_HI            2
`define MASTER_SEL_LO            0
`define AHB_DIV_MAX              4'h9
`define APB_DIV_MAX              3'h4

`define SRC_SLOW                 3'h0
`define SRC_SUB                  3'h1
`define SRC_FAST                 3'h2
`define SRC_MASTER               3'h4
`define SRC_FAST_OUT             3'h5
`define SRC_MAIN                 3'h6
`define SRC_PLL                  3'h7

`define MON_GROUP_WIDTH          4
`define MON_ENABLE_POS           3
`define MON_IRQ_EN_POS           2
`define MON_FAIL_POS             1
`define MON_STOPPED_POS          0
`define MON_SUB                  2
`define MON_MASTER               1
`define MON_MAIN                 0

`define CLOCK_OUT_PIN_SRC_HI              7
`define CLOCK_OUT_PIN_SRC_LO              5
`define CLOCK_OUT_PIN_EN_BIT              4
`define CLOCK_OUT_PIN_DIV_HI              3
`define CLOCK_OUT_PIN_DIV_LO              0

`define NMI_PRIO_HI              23
`define NMI_PRIO_LO              16
`define NMI_GLOBAL_BIT           15
`define NMI_PWM_B_PROT_BIT       6
`define NMI_MASTER_FAIL_BIT      1

`endif

// *** testbench/system_clock_control_properties.sv ***
// Concurrent checks on the ports of the system clock control block
`timescale 1ns/10ps
`default_nettype none
module system_clock_control_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        powerRst_n,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [31:0] rdData,
    input wire logic        apbClock,
    input wire logic [31:0] peripheralClock,
    input wire logic        pwmBProtectIrq,
    input wire logic        subCrystalFailIrq,
    input wire logic        masterFailIrq,
    input wire logic        mainCrystalFailIrq,
    input wire logic        nmiRequest,
    input wire logic        subCrystalEnable,
    input wire logic        slowInternalOscEnable,
    input wire logic        subCrystalPowerDownKeep,
    input wire logic        nmiPriorityEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_one_cycle: assert property (!$past(rdStrobe) |-> rdData == 32'h0)
        else $error("read data outside its cycle");
    a_gate_follows_apb: assert property (peripheralClock != 32'h0 |-> $past(apbClock))
        else $error("peripheral clock high without bus clock");
    a_nmi_has_cause: assert property (nmiRequest |-> pwmBProtectIrq || masterFailIrq)
        else $error("nmi request without a routed source");
    a_keep_implies_on: assert property (subCrystalPowerDownKeep |-> subCrystalEnable)
        else $error("power-down pattern without sub crystal enable");
    a_main_fail_drop: assert property ($fell(mainCrystalFailIrq) |-> $past(wrStrobe))
        else $error("main crystal failure dropped without a write");
    a_master_fail_drop: assert property ($fell(masterFailIrq) |-> $past(wrStrobe))
        else $error("master failure dropped without a write");
    a_sub_fail_drop: assert property ($fell(subCrystalFailIrq) |-> $past(wrStrobe))
        else $error("sub crystal failure dropped without a write");
    a_slow_en_write: assert property ($changed(slowInternalOscEnable) |-> $past(wrStrobe))
        else $error("slow oscillator enable changed without a write");
    a_sub_en_kept: assert property ($changed(subCrystalEnable) |-> $past(wrStrobe) || !$past(powerRst_n))
        else $error("sub crystal enable changed without write or power reset");
    a_nmi_en_write: assert property ($changed(nmiPriorityEnable) |-> $past(wrStrobe))
        else $error("nmi enable changed without a write");
endmodule
bind system_clock_control system_clock_control_properties system_clock_control_properties_i (
    .clk(clk), .rst_n(rst_n), .powerRst_n(powerRst_n), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .apbClock(apbClock), .peripheralClock(peripheralClock),
    .pwmBProtectIrq(pwmBProtectIrq), .subCrystalFailIrq(subCrystalFailIrq),
    .masterFailIrq(masterFailIrq), .mainCrystalFailIrq(mainCrystalFailIrq), .nmiRequest(nmiRequest),
    .subCrystalEnable(subCrystalEnable), .slowInternalOscEnable(slowInternalOscEnable),
    .subCrystalPowerDownKeep(subCrystalPowerDownKeep), .nmiPriorityEnable(nmiPriorityEnable));
`default_nettype wire

// *** testbench/system_clock_control_bench.sv ***
// Self-checking bench for the system clock control block
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_defines.vh"
module system_clock_control_bench;
    logic        clk, rst_n, powerRst_n, wrStrobe, rdStrobe, pwmIrq, mainRun, rdWas;
    logic        slowOsc, mainOsc, masterClock, ahbClock, apbClock, clockOutPin;
    logic        subEn, subKeep, subIrq, masterIrq, mainIrq, nmiEnable, nmiRequest;
    logic [31:0] addr, wrData, rdData, peripheralClock, r;
    logic [7:0]  nmiPrio;
    logic [2:0]  tick;
    logic [5:0]  sig, sigPrev;
    logic [31:0] expQ [$];
    int          bad_count, checks_done, cycles, rises [6], base [6];
    // Register, value, watched clock, log2 of ratio to master (-1 means silent)
    logic [31:0] tA [12] = '{`ADDR_SYS_CLOCK_SELECT, `ADDR_SYS_CLOCK_SELECT, `ADDR_SYS_CLOCK_SELECT,
        `ADDR_SYS_CLOCK_SELECT, `ADDR_SYS_CLOCK_SELECT, `ADDR_SYS_CLOCK_SELECT, `ADDR_PERIPH_GATE_TWO,
        `ADDR_PERIPH_GATE_TWO, `ADDR_CLOCK_OUTPUT, `ADDR_CLOCK_OUTPUT, `ADDR_CLOCK_OUTPUT,
        `ADDR_CLOCK_OUTPUT};
    logic [31:0] tV [12] = '{32'h00000000, 32'h01000000, 32'h02000000, 32'h0A000000, 32'h01010000,
        32'h01050000, 32'h00000001, 32'h00000001, 32'h00000000, 32'h00000010, 32'h00000012,
        32'h00000090};
    int          tI [12] = '{1, 1, 1, 1, 2, 2, 4, 5, 3, 3, 3, 3};
    int          tS [12] = '{0, 1, 2, 2, 2, 2, 2, -1, -1, 0, 2, 0};

    system_clock_control system_clock_control_i (.clk(clk), .rst_n(rst_n), .powerRst_n(powerRst_n),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .slowInternalOsc(slowOsc), .subCrystalOsc(1'b0), .fastInternalOsc(1'b0),
        .mainCrystalOsc(mainOsc), .pllOutputClock(1'b0), .pwmBProtectIrq(pwmIrq),
        .subCrystalEnable(subEn), .slowInternalOscEnable(), .fastInternalOscEnable(),
        .mainCrystalEnable(), .subCrystalPowerDownKeep(subKeep), .masterClock(masterClock),
        .ahbClock(ahbClock), .apbClock(apbClock), .peripheralClock(peripheralClock),
        .pllInputClock(), .clockOutPin(clockOutPin), .subCrystalFailIrq(subIrq),
        .masterFailIrq(masterIrq), .mainCrystalFailIrq(mainIrq), .nmiPrioritySource(nmiPrio),
        .nmiPriorityEnable(nmiEnable), .nmiRequest(nmiRequest));

    assign sig = {peripheralClock[8], peripheralClock[0], clockOutPin, apbClock, ahbClock, masterClock};

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input int tol = 0);
        checks_done++;
        if ((tol == 0 && g !== e) || (tol != 0 && (int'(g) - int'(e) > tol || int'(e) - int'(g) > tol))) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        if (!w) expQ.push_back(d);
        addr <= a; wrData <= d; wrStrobe <= w; rdStrobe <= !w;
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        wrStrobe <= 1'b0; rdStrobe <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Oscillator models, edge counters, read monitor and hang guard
    always @(posedge clk) begin
        tick <= tick + 3'h1;
        slowOsc <= tick[2];
        mainOsc <= mainRun & tick[1];
        sigPrev <= sig;
        for (int i = 0; i < 6; i++) if (sig[i] & !sigPrev[i]) rises[i] <= rises[i] + 1;
        if (rdWas === 1'b1) chk("rdData", expQ.pop_front(), rdData);
        rdWas <= rdStrobe;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict;
        end
    end

    initial begin
        {rst_n, powerRst_n, wrStrobe, rdStrobe, pwmIrq, mainRun, rdWas} = 7'h0;
        addr = 32'h0; wrData = 32'h0; tick = 3'h0; sigPrev = 6'h0; cycles = 0;
        rises = '{default: 0};
        void'($urandom(23));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1; powerRst_n <= 1'b1;
        @(posedge clk);
        bus(0, `ADDR_PERIPH_GATE_TWO, `RST_PERIPH_GATE_TWO);
        bus(0, `ADDR_OSC_SOURCE_ENABLE, 32'h00000100);
        bus(0, `ADDR_SYS_CLOCK_SELECT, 32'h0);
        bus(0, 32'h40000038, 32'h0);
        r = $urandom;
        bus(1, `ADDR_PERIPH_GATE_TWO, r);
        bus(0, `ADDR_PERIPH_GATE_TWO, r & `MASK_PERIPH_GATE_TWO);
        r = $urandom;
        bus(1, `ADDR_NMI_CONTROL, r);
        bus(0, `ADDR_NMI_CONTROL, r & `MASK_NMI_CONTROL);
        cyc(1);
        chk("nmiPrio", {24'h0, r[23:16]}, {24'h0, nmiPrio});
        chk("nmiEnable", {31'h0, r[15]}, {31'h0, nmiEnable});
        for (int k = 0; k < 12; k++) begin
            bus(1, tA[k], tV[k]);
            cyc(48);
            base = rises;
            cyc(256);
            chk("clock rises", tS[k] < 0 ? 0 : (rises[0] - base[0]) >> tS[k], rises[tI[k]] - base[tI[k]], 1);
        end
        bus(1, `ADDR_OSC_SOURCE_ENABLE, 32'h0000C100);
        cyc(1);
        chk("subKeep", 32'h1, {31'h0, subKeep});
        chk("subEn", 32'h1, {31'h0, subEn});
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(0, `ADDR_OSC_SOURCE_ENABLE, 32'h0000C100);
        cyc(1);
        {rst_n, powerRst_n} <= 2'b00;
        cyc(2);
        {rst_n, powerRst_n} <= 2'b11;
        @(posedge clk);
        bus(0, `ADDR_OSC_SOURCE_ENABLE, 32'h00000100);
        bus(1, `ADDR_OSC_SOURCE_ENABLE, 32'h00000101);
        mainRun <= 1'b1;
        bus(1, `ADDR_CLOCK_MONITOR, 32'h00000C0C);
        cyc(40);
        bus(0, `ADDR_CLOCK_MONITOR, 32'h00000C0C);
        cyc(1);
        chk("mainIrq", 32'h0, {31'h0, mainIrq});
        mainRun <= 1'b0;
        cyc(40);
        bus(0, `ADDR_CLOCK_MONITOR, 32'h00000C0F);
        cyc(1);
        chk("mainIrq", 32'h1, {31'h0, mainIrq});
        // Stop monitoring first so that no window end meets the clear
        bus(1, `ADDR_CLOCK_MONITOR, 32'h00000004);
        bus(1, `ADDR_CLOCK_MONITOR, 32'h00000006);
        cyc(20);
        bus(0, `ADDR_CLOCK_MONITOR, 32'h00000004);
        bus(1, `ADDR_NMI_CONTROL, 32'h00000040);
        pwmIrq <= 1'b1;
        cyc(1);
        chk("nmiRequest", 32'h1, {31'h0, nmiRequest});
        bus(1, `ADDR_NMI_CONTROL, 32'h0);
        cyc(1);
        chk("nmiRequest", 32'h0, {31'h0, nmiRequest});
        cyc(2);
        print_verdict;
    end
endmodule
`default_nettype wire
